// ### core/pcd_cap_list.v
// Purpose: Config space capability list with a power management item
// Assumes: Single-cycle config read/write strobes on the PCI clock
// Notes:   Reads answer one cycle later; unmapped space reads zero
`timescale 1ns/1ps
`include "pcd_defs.vh"

module pcd_cap_list #(
  parameter       CAP_EN     = 1,
  parameter       D1_SUP     = 1,
  parameter       D2_SUP     = 1,
  parameter [4:0] PME_SUP    = 5'h0f,
  parameter       FUNC_NUM   = 0,
  parameter [7:0] SHARED_PWR = 8'h00,
  parameter       NFUNC      = 1
) (
  // Clock, reset, enable
  input  wire                 clk,
  input  wire                 sys_rst,
  input  wire                 clk_en,
  // Configuration access
  input  wire [5:0]           cfg_dw,
  input  wire [3:0]           cfg_be,
  input  wire                 cfg_rd,
  input  wire                 cfg_wr,
  input  wire [31:0]          cfg_wdata,
  output reg  [31:0]          cfg_rdata_q,
  output reg                  cfg_rvalid_q,
  // Wake event pin and request
  input  wire                 wake_event,
  output reg                  wake_req_q,
  // Power state seen by the function
  output reg  [1:0]           power_state_q,
  // Other functions' states for the shared logic
  input  wire [2*NFUNC-1:0]   other_states,
  output reg                  shared_off_q
);

  // Control and status state
  reg        pme_en_q;
  reg        pme_en_d;
  reg        pme_st_q;
  reg        pme_st_d;
  reg [1:0]  power_state_d;
  reg [7:0]  data_sel_q;
  reg [7:0]  data_sel_d;
  reg        wake_req_d;
  // Read return path
  reg [31:0] cfg_rdata_d;
  reg        cfg_rvalid_d;
  // Wake pin synchroniser and agreed level
  reg        ev_s1_q;
  reg        ev_s2_q;
  reg        ev_s3_q;
  reg        ev_seen_q;
  reg        ev_seen_d;
  // Shared interface logic
  reg        shared_off_d;
  wire       shared_off_w;
  reg [2*NFUNC-1:0] all_states;

  // Byte lane enable spread over a whole byte
  function [7:0] be_mask;
    input [3:0] be;
    input integer lane;
    be_mask = {8{be[lane]}};
  endfunction

  // True for the control/status dword of the power item
  function is_csr_dw;
    input [5:0] dw;
    is_csr_dw = (dw == `PCD_PM_DW + 6'h01);
  endfunction

  // True when the function may enter the requested state
  function state_legal;
    input [1:0] st;
    begin
      case (st)
        `PCD_D0:    state_legal = 1'b1;
        `PCD_D1:    state_legal = (D1_SUP != 0);
        `PCD_D2:    state_legal = (D2_SUP != 0);
        `PCD_D3HOT: state_legal = 1'b1;
        default:    state_legal = 1'b0;
      endcase
    end
  endfunction

  // Wake reporting allowed from the given state
  function wake_allowed;
    input [1:0] st;
    wake_allowed = PME_SUP[st];
  endfunction

  // Status upper half: capabilities bit only, rest zero
  wire [15:0] status_w = (CAP_EN != 0) ? (16'h0001 << `PCD_CAP_BIT) : 16'h0000;
  // Pointer forced DWORD aligned, zero when the list is disabled
  wire [7:0]  cap_ptr_w = (CAP_EN != 0) ? (`PCD_PM_OFS & 8'hfc) : 8'h00;

  // Capability word
  wire [15:0] pmc_w = ({13'h0000, `PCD_PM_VERSION} << `PCD_PMC_VER_LSB)
                    | ((D1_SUP != 0) ? (16'h0001 << `PCD_PMC_D1_BIT) : 16'h0000)
                    | ((D2_SUP != 0) ? (16'h0001 << `PCD_PMC_D2_BIT) : 16'h0000)
                    | ({11'h000, PME_SUP} << `PCD_PMC_PME_LSB);
  wire [15:0] csr_w = ({14'h0000, power_state_q} << `PCD_CSR_STATE_LSB)
                    | ({15'h0000, pme_en_q} << `PCD_CSR_PME_EN_BIT)
                    | ({15'h0000, pme_st_q} << `PCD_CSR_PME_ST_BIT);
  wire [7:0]  data_w = (FUNC_NUM == 0 && data_sel_q == 8'h00) ? SHARED_PWR : 8'h00;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (cfg_dw)
      `PCD_STATUS_DW: rd_mux = {status_w, 16'h0000};
      `PCD_CAPPTR_DW: rd_mux = {24'h00_0000, cap_ptr_w};
      `PCD_PM_DW: begin
        if (CAP_EN != 0) begin
          rd_mux = {pmc_w, `PCD_NEXT_END, `PCD_PM_ID};
        end
      end
      `PCD_PM_DW + 6'h01: begin
        if (CAP_EN != 0) begin
          rd_mux = {data_w, 8'h00, csr_w};
        end
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Write decode for the control/status dword
  wire       csr_wr      = cfg_wr && (CAP_EN != 0) && is_csr_dw(cfg_dw);
  wire       csr_wr_b0   = csr_wr && cfg_be[0];
  wire       csr_wr_b1   = csr_wr && cfg_be[1];
  wire       csr_wr_b3   = csr_wr && cfg_be[3];
  wire [1:0] req_state   = cfg_wdata[`PCD_CSR_STATE_LSB +: 2];
  wire       pme_allowed = wake_allowed(power_state_q);
  wire       ev_rise     = ev_s2_q && ev_s3_q && !ev_seen_q;
  wire       pme_set     = ev_rise && pme_allowed;
  wire       pme_clr     = csr_wr_b1 && cfg_wdata[`PCD_CSR_PME_ST_BIT];

  // Read data captured with the strobe, held until the next read
  always @* begin
    cfg_rvalid_d = cfg_rd;
    cfg_rdata_d  = cfg_rdata_q;
    if (cfg_rd) begin
      cfg_rdata_d = rd_mux;
    end
  end

  // Requested state taken only when the function supports it
  always @* begin
    power_state_d = power_state_q;
    if (csr_wr_b0 && state_legal(req_state)) begin
      power_state_d = req_state;
    end
  end

  always @* begin
    pme_en_d = pme_en_q;
    if (csr_wr_b1) begin
      pme_en_d = cfg_wdata[`PCD_CSR_PME_EN_BIT];
    end
  end

  // Set wins over write-one-to-clear
  always @* begin
    pme_st_d = pme_st_q;
    if (pme_set) begin
      pme_st_d = 1'b1;
    end else if (pme_clr) begin
      pme_st_d = 1'b0;
    end
  end

  always @* begin
    data_sel_d = data_sel_q;
    if (csr_wr_b3) begin
      data_sel_d = cfg_wdata[31:24] & be_mask(cfg_be, 3);
    end
  end

  // Armed status, or a fresh event in the same cycle, raises the request
  always @* begin
    wake_req_d = pme_en_q && (pme_st_q || pme_set);
  end

  // Agreed level moves only when the last two stages match
  always @* begin
    ev_seen_d = ev_seen_q;
    if (ev_s2_q == ev_s3_q) begin
      ev_seen_d = ev_s3_q;
    end
  end

  // Own state replaces the lowest slot of the other functions
  always @* begin
    all_states      = other_states;
    all_states[1:0] = power_state_q;
    shared_off_d    = shared_off_w;
  end

  // Read path registers
  always @(posedge clk) begin
    if (sys_rst) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else if (clk_en) begin
      cfg_rdata_q  <= cfg_rdata_d;
      cfg_rvalid_q <= cfg_rvalid_d;
    end
  end

  // Control and status registers, defined straight from reset
  always @(posedge clk) begin
    if (sys_rst) begin
      power_state_q <= `PCD_D0;
    end else if (clk_en) begin
      power_state_q <= power_state_d;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pme_en_q <= 1'b0;
    end else if (clk_en) begin
      pme_en_q <= pme_en_d;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      pme_st_q <= 1'b0;
    end else if (clk_en) begin
      pme_st_q <= pme_st_d;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      data_sel_q <= 8'h00;
    end else if (clk_en) begin
      data_sel_q <= data_sel_d;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wake_req_q <= 1'b0;
    end else if (clk_en) begin
      wake_req_q <= wake_req_d;
    end
  end

  // Wake pin: three stages, a change counts once stages two and three agree
  always @(posedge clk) begin
    if (sys_rst) begin
      ev_s1_q   <= 1'b0;
      ev_s2_q   <= 1'b0;
      ev_s3_q   <= 1'b0;
      ev_seen_q <= 1'b0;
    end else if (clk_en) begin
      ev_s1_q   <= wake_event;
      ev_s2_q   <= ev_s1_q;
      ev_s3_q   <= ev_s2_q;
      ev_seen_q <= ev_seen_d;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      shared_off_q <= 1'b0;
    end else if (clk_en) begin
      shared_off_q <= shared_off_d;
    end
  end

  pcd_shared_power #(
    .NFUNC (NFUNC)
  ) u_shared (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .func_state   (all_states),
    .shared_off_q (shared_off_w)
  );

endmodule // pcd_cap_list

// ### shared/pcd_defs.vh
// Purpose: Constants for the capability list discovery block
// Assumes: Config space addressed by DWORD number, byte enables per lane
// Notes:   Offsets are byte addresses in configuration space
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH

`define PCD_STATUS_OFS        8'h06
`define PCD_STATUS_DW         6'h01
`define PCD_CAP_BIT           4
`define PCD_CAPPTR_OFS        8'h34
`define PCD_CAPPTR_DW         6'h0d
`define PCD_HDR_END           8'h40
`define PCD_PM_OFS            8'h40
`define PCD_PM_DW             6'h10
`define PCD_PM_ID             8'h01
`define PCD_NEXT_END          8'h00
`define PCD_PM_VERSION        3'h3
`define PCD_PMC_VER_LSB       0
`define PCD_PMC_D1_BIT        9
`define PCD_PMC_D2_BIT        10
`define PCD_PMC_PME_LSB       11
`define PCD_CSR_STATE_LSB     0
`define PCD_CSR_PME_EN_BIT    8
`define PCD_CSR_PME_ST_BIT    15
`define PCD_D0                2'h0
`define PCD_D1                2'h1
`define PCD_D2                2'h2
`define PCD_D3HOT             2'h3

`endif

// ### core/pcd_shared_power.v
// Purpose: Shared bus interface power control for a multi-function part
// Assumes: Each function reports its current power state, two bits each
// Notes:   Logic powers down only once every function sits in D3hot
`timescale 1ns/1ps
`include "pcd_defs.vh"

module pcd_shared_power #(
  parameter NFUNC = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             clk_en,
  // Function states
  input  wire [2*NFUNC-1:0] func_state,
  // Shared logic control
  output reg              shared_off_q
);

  reg all_d3;
  integer i;

  always @* begin
    all_d3 = 1'b1;
    for (i = 0; i < NFUNC; i = i + 1) begin
      if (func_state[2*i +: 2] != `PCD_D3HOT) begin
        all_d3 = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      shared_off_q <= 1'b0;
    end else if (clk_en) begin
      shared_off_q <= all_d3;
    end
  end

endmodule // pcd_shared_power

// ### tb/pcd_host_model.sv
// Purpose: Host side issuing config reads and writes
// Assumes: One access per rd or wr call, driven on falling edges
// Notes:   Idle data lines carry the inverse of the last value
`timescale 1ns/1ps
module pcd_host_model (
  // Clock and answer
  input  wire        clk,
  input  wire [31:0] cfg_rdata_q,
  input  wire        cfg_rvalid_q,
  // Request
  output reg  [5:0]  cfg_dw = 6'h00,
  output reg  [3:0]  cfg_be = 4'h0,
  output reg         cfg_rd = 1'b0,
  output reg         cfg_wr = 1'b0,
  output reg  [31:0] cfg_wdata = 32'h0
);
  task rd(input [5:0] dw, output [31:0] d);
    begin
      @(negedge clk);
      cfg_dw = dw;
      cfg_rd = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      cfg_dw = ~dw;
      d = cfg_rvalid_q ? cfg_rdata_q : 32'hdeadbeef;
    end
  endtask
  task wr(input [5:0] dw, input [3:0] be, input [31:0] d);
    begin
      @(negedge clk);
      cfg_dw = dw;
      cfg_be = be;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      cfg_wdata = ~d;
    end
  endtask
  // Follow links looking for the power item
  task walk(output ok);
    reg [31:0] d;
    reg [7:0]  p;
    integer    n;
    begin
      ok = 1'b0;
      p = 8'h00;
      rd(6'h01, d);
      if (d[20]) begin
        rd(6'h0d, d);
        p = d[7:0];
      end
      for (n = 0; n < 48 && p >= 8'h40; n = n + 1) begin
        rd(p[7:2], d);
        if (d[7:0] == 8'h01) ok = 1'b1;
        p = d[15:8];
      end
    end
  endtask
endmodule // pcd_host_model

// ### tb/pcd_cap_list_assertions.sv
// Purpose: Port checker for the capability list
// Assumes: Default parameters, list enabled
// Notes:   Bound after the module
`timescale 1ns/1ps
module pcd_chk (
  // Clock and request
  input wire        clk,
  input wire        sys_rst,
  input wire        clk_en,
  input wire        cfg_rd,
  input wire        cfg_wr,
  input wire [5:0]  cfg_dw,
  input wire [3:0]  cfg_be,
  input wire [31:0] cfg_wdata,
  // Results
  input wire [31:0] cfg_rdata_q,
  input wire        cfg_rvalid_q,
  input wire        shared_off_q,
  input wire [1:0]  power_state_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire rd = cfg_rd && clk_en;
  wire sw = cfg_wr && clk_en && cfg_dw == 6'h11 && cfg_be[0];
  a_read_answer: assert property (rd |=> cfg_rvalid_q)
    else $error("read not answered");
  a_ptr_value: assert property (rd && cfg_dw == 6'h0d |=> cfg_rdata_q == 32'h40)
    else $error("bad pointer");
  a_cap_flag: assert property (rd && cfg_dw == 6'h01 |=> cfg_rdata_q[20])
    else $error("flag low");
  a_item_head: assert property (rd && cfg_dw == 6'h10 |=> cfg_rdata_q[15:0] == 16'h0001)
    else $error("bad item head");
  a_hole_zero: assert property (rd && cfg_dw > 6'h11 |=> cfg_rdata_q == 32'h0)
    else $error("hole not zero");
  a_state_set: assert property (sw |=> power_state_q == $past(cfg_wdata[1:0]))
    else $error("state not set");
  a_state_hold: assert property (!sw |=> $stable(power_state_q))
    else $error("state moved");
  a_shared_down: assert property ((clk_en && power_state_q == 2'h3) [*2] |=> shared_off_q)
    else $error("shared not off");
  cover property (rd && cfg_dw == 6'h10);
  cover property (sw);
  cover property (shared_off_q);
endmodule // pcd_chk
bind pcd_cap_list pcd_chk u_chk (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_dw(cfg_dw), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .shared_off_q(shared_off_q),
  .power_state_q(power_state_q));

// ### tb/pcd_cap_list_bench.sv
// Purpose: Self-checking bench for the capability list
// Assumes: Single function, shared power byte 5ah
// Notes:   Host model drives the config port
`timescale 1ns/1ps
module pcd_cap_list_bench;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         clk_en = 1'b1;
  reg         wake_event = 1'b0;
  wire [5:0]  dw;
  wire [3:0]  be;
  wire        rd, wr, rv, wk, so;
  wire [31:0] wd, rdat;
  wire [1:0]  ps;
  integer     err_total = 0;
  integer     n_compared = 0;
  integer     s;
  reg [31:0]  d;
  reg         ok;
  always #2 clk = ~clk;
  pcd_cap_list #(.SHARED_PWR(8'h5a)) u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cfg_dw(dw), .cfg_be(be), .cfg_rd(rd), .cfg_wr(wr), .cfg_wdata(wd), .cfg_rdata_q(rdat),
    .cfg_rvalid_q(rv), .wake_event(wake_event), .wake_req_q(wk), .power_state_q(ps),
    .other_states(2'h0), .shared_off_q(so));
  pcd_host_model u_host (.clk(clk), .cfg_rdata_q(rdat), .cfg_rvalid_q(rv), .cfg_dw(dw),
    .cfg_be(be), .cfg_rd(rd), .cfg_wr(wr), .cfg_wdata(wd));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task t_list;
    begin
      u_host.rd(6'h01, d);
      chk(d[20], 1'b1);
      u_host.rd(6'h0d, d);
      chk(d, 32'h40);
      u_host.rd(6'h10, d);
      chk(d[15:0], 16'h0001);
      chk({d[31:25], d[18:16]}, {7'h3f, 3'h3});
      u_host.walk(ok);
      chk(ok, 1'b1);
      u_host.wr(6'h0d, 4'hf, 32'hffffffff);
      u_host.rd(6'h0d, d);
      chk(d, 32'h40);
      u_host.rd(6'h3f, d);
      chk(d, 32'h0);
      $display("list test done");
    end
  endtask
  task t_state;
    begin
      for (s = 0; s < 4; s = s + 1) begin
        u_host.wr(6'h11, 4'h1, s);
        chk(ps, s[1:0]);
        u_host.rd(6'h11, d);
        chk(d[1:0], s[1:0]);
      end
      chk(so, 1'b1);
      chk(d[31:24], 8'h5a);
      u_host.wr(6'h11, 4'h3, 32'h00008100);
      u_host.rd(6'h11, d);
      chk(so, 1'b0);
      wake_event = 1'b1;
      for (s = 0; s < 12 && wk !== 1'b1; s = s + 1) @(negedge clk);
      chk(wk, 1'b1);
      wake_event = 1'b0;
      $display("state test done");
    end
  endtask
  task t_freeze;
    begin
      clk_en = 1'b0;
      u_host.wr(6'h11, 4'h1, 32'h3);
      chk(ps, 2'h0);
      chk(wk, 1'b1);
      clk_en = 1'b1;
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk({wk, so, ps}, 4'h0);
      u_host.rd(6'h11, d);
      chk(d[15:0], 16'h0000);
      $display("freeze and reset test done");
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_list;
    t_state;
    t_freeze;
    complete_run;
  end
  initial begin
    #4000;
    err_total = err_total + 1;
    complete_run;
  end
endmodule // pcd_cap_list_bench
